/* core/ppc_map.vh */
// Constants for the picture processor control and decode block
//------------------------------------------------------------------
// Behaviour
//------------------------------------------------------------------
`ifndef PPC_MAP_VH
`define PPC_MAP_VH
// Register byte offsets
`define A_CTRL    6'h00
`define A_EXT_HI  6'h04
`define A_EXT_LO  6'h08
`define A_PC      6'h0C
`define A_DMA_ADR 6'h10
`define A_DMA_LO  6'h14
`define A_DMA_HI  6'h18
`define A_DECODE  6'h1C
// Control register bits
`define C_CONT  0
`define C_HALT  1
`define C_CLEAR 2
`define C_LDPC  3
// DMA targets
`define T_PROG  2'h0
`define T_UCODE 2'h1
`define T_LINE  2'h2
`define T_DATA  2'h3
// Memory depths
`define PM_DEPTH 4096
`define UC_DEPTH 4096
`define LB_DEPTH 2304
`define DF_DEPTH 4096
`define RS_DEPTH 64
// Microword fields
`define UF_ADDR  11:0
`define UF_SEQ   14:12
`define UF_ALU   17:15
`define UF_COND  57
`define UF_JUMP  58
`define UF_STORE 59
// Microsequencer operations
`define SQ_NEXT 3'h0
`define SQ_JUMP 3'h1
`define SQ_CALL 3'h2
`define SQ_RET  3'h3
`define SQ_LOAD 3'h4
`define SQ_INC  3'h5
`define SQ_DEC  3'h6
`define SQ_END  3'h7
// Operand modes
`define M_NORM 2'h0
`define M_IMM  2'h1
`define M_IND  2'h2
`define M_BAD  2'h3
`endif

/* core/picture_processor_control_decode.v */
// Microprogrammed control and instruction decode for the picture processor
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`include "ppc_map.vh"
module picture_processor_control_decode (
    input  wire        core_clk,        // System clock, 20 MHz
    input  wire        reset_n,         // Asynchronous reset, active low
    input  wire [5:0]  avs_address,     // Avalon byte address
    input  wire        avs_read,        // Avalon read
    input  wire        avs_write,       // Avalon write
    input  wire [31:0] avs_writedata,   // Avalon write data
    input  wire [3:0]  avs_byteenable,  // Avalon byte enables
    output reg  [31:0] avs_readdata,    // Avalon read data
    output reg         avs_waitrequest, // Avalon wait request
    output reg  [59:0] micro_enable,    // Microcode enable bus
    output reg  [2:0]  debug_state,     // Next-state code, octal digit
    output reg         run_flag,        // Run flip-flop
    output reg         trap_flag,       // Illegal mode or undefined opcode trap
    output reg  [3:0]  group_id         // Decoded operator group
);
    localparam S_IDLE   = 5'h01;
    localparam S_FETCH  = 5'h02;
    localparam S_DECODE = 5'h04;
    localparam S_OPER   = 5'h08;
    localparam S_MICRO  = 5'h10;

    //--------------------------------------------------------------
    // Reset synchroniser
    //--------------------------------------------------------------
    reg rst_meta_r;
    reg rst_n_r;
    // Release is synchronous so no flop sees a partial release
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    //--------------------------------------------------------------
    // Storage
    //--------------------------------------------------------------
    reg [59:0] instruction_memory [0:`PM_DEPTH-1];
    reg [59:0] microcode_store    [0:`UC_DEPTH-1];
    reg [15:0] line_mem           [0:`LB_DEPTH-1];
    reg [15:0] data_mem           [0:`DF_DEPTH-1];
    reg [11:0] ret_stack          [0:`RS_DEPTH-1];

    reg [4:0]  state_r;
    reg [23:0] program_counter_r;
    reg [59:0] ir_r;
    reg [59:0] prefetch_r;
    reg [11:0] upc_r;
    reg [5:0]  sp_r;
    reg [11:0] uctr_r;
    reg [15:0] src1_r;
    reg [15:0] src2_r;
    reg [11:0] dst_r;
    reg [11:0] ext_hi_r;
    reg [11:0] ext_lo_r;
    reg [13:0] dma_adr_r;
    reg [31:0] dma_lo_r;

    //--------------------------------------------------------------
    // Decode of the current instruction
    //--------------------------------------------------------------
    // Operator bit 0 of the field is the lsb of the word's top 12 bits
    wire [11:0] opr    = ir_r[59:48];
    wire        m_dst  = opr[11];
    wire [1:0]  m1     = opr[10:9];
    wire [1:0]  m2     = opr[8:7];
    wire [6:0]  opcode = opr[6:0];
    wire [15:0] f3     = ir_r[47:32];
    wire [15:0] f1     = ir_r[31:16];
    wire [15:0] f2     = ir_r[15:0];
    wire        bad_mode = (m1 == `M_BAD) | (m2 == `M_BAD);
    reg  [3:0]  grp;

    // Opcode equals the group base plus subgroup, so it doubles as dispatch index
    always @* begin
        casez (opcode)
            7'b000000?: grp = 4'h1;
            7'b000001?: grp = 4'h2;
            7'b0001???: grp = 4'h4;
            7'b0010???: grp = 4'h5;
            7'b0011???: grp = 4'h6;
            7'b01000??: grp = 4'h7;
            7'b01001??: grp = 4'h8;
            7'b0101???: grp = 4'h9;
            7'b100????: grp = 4'hA;
            7'b101????: grp = 4'h3;
            7'b11000??: grp = 4'hB;
            7'b11001??: grp = 4'hC;
            7'b11010??: grp = 4'hD;
            default:    grp = 4'h0;
        endcase
    end

    // Operand resolution: one read for normal, two chained for indirect
    wire [15:0] ptr1 = data_mem[f1[11:0]];
    wire [15:0] ptr2 = data_mem[f2[11:0]];
    wire [15:0] ptr3 = data_mem[f3[11:0]];
    wire [15:0] ind1 = data_mem[ptr1[11:0]];
    wire [15:0] ind2 = data_mem[ptr2[11:0]];
    wire [15:0] imm1 = {4'h0, f1[11:0]};
    wire [15:0] imm2 = {4'h0, f2[11:0]};
    wire [15:0] src1 = (m1 == `M_IMM) ? imm1 : (m1 == `M_IND) ? ind1 : ptr1;
    wire [15:0] src2 = (m2 == `M_IMM) ? imm2 : (m2 == `M_IND) ? ind2 : ptr2;
    wire [11:0] dst  = m_dst ? ptr3[11:0] : f3[11:0];

    //--------------------------------------------------------------
    // Microword and operation unit
    //--------------------------------------------------------------
    wire [59:0] uword = microcode_store[upc_r];
    wire [2:0]  useq  = uword[`UF_SEQ];
    wire [11:0] uadr  = uword[`UF_ADDR];
    wire [11:0] upc_inc = upc_r + 12'h001;
    wire [5:0]  sp_dec  = sp_r - 6'h01;
    wire        in_micro = (state_r == S_MICRO);
    wire        u_end    = in_micro & (useq == `SQ_END);
    wire        jump_hit = uword[`UF_JUMP] & (~uword[`UF_COND] | (src1_r == src2_r));
    wire        do_store = u_end & uword[`UF_STORE] & ~uword[`UF_JUMP];
    reg  [15:0] alu;

    // Small operation unit picked per microword; richer arithmetic lives elsewhere
    always @* begin
        case (uword[`UF_ALU])
            3'h0:    alu = src1_r;
            3'h1:    alu = src1_r + src2_r;
            3'h2:    alu = src1_r - src2_r;
            3'h3:    alu = src1_r & src2_r;
            3'h4:    alu = src1_r | src2_r;
            3'h5:    alu = src1_r ^ src2_r;
            3'h6:    alu = src2_r;
            default: alu = ~src1_r;
        endcase
    end

    //--------------------------------------------------------------
    // Bus decode
    //--------------------------------------------------------------
    wire        bus_wr  = avs_write & ~avs_waitrequest;
    wire        bus_rd  = avs_read & avs_waitrequest;
    wire        stopped = ~run_flag;
    wire [1:0]  dma_tgt = dma_adr_r[13:12];
    wire [11:0] dma_idx = dma_adr_r[11:0];
    // Memory loads are refused while running so the program cannot change mid-flight
    wire        dma_go  = bus_wr & (avs_address == `A_DMA_HI) & stopped;
    wire [59:0] dma_word = {avs_writedata[27:0], dma_lo_r};
    wire        line_ok = (dma_idx < `LB_DEPTH);
    reg  [59:0] dma_rd;

    // Host view of the selected memory word
    always @* begin
        case (dma_tgt)
            `T_PROG:  dma_rd = instruction_memory[dma_idx];
            `T_UCODE: dma_rd = microcode_store[dma_idx];
            `T_LINE:  dma_rd = line_ok ? {44'h0, line_mem[dma_idx]} : 60'h0;
            default:  dma_rd = {44'h0, data_mem[dma_idx]};
        endcase
    end

    //--------------------------------------------------------------
    // Memory writes
    //--------------------------------------------------------------
    // Host writes need the run flag off, yet a halted instruction still finishing can store in the same cycle; its store wins
    always @(posedge core_clk) begin
        if (dma_go) begin
            case (dma_tgt)
                `T_PROG:  instruction_memory[dma_idx] <= dma_word;
                `T_UCODE: microcode_store[dma_idx] <= dma_word;
                `T_LINE:  if (line_ok) line_mem[dma_idx] <= dma_word[15:0];
                default:  data_mem[dma_idx] <= dma_word[15:0];
            endcase
        end
        if (do_store)
            data_mem[dst_r] <= alu;
        if (in_micro & (useq == `SQ_CALL))
            ret_stack[sp_r] <= upc_inc;
    end

    //--------------------------------------------------------------
    // Avalon slave: one wait cycle on every access
    //--------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (bus_rd) begin
                case (avs_address)
                    `A_CTRL:    avs_readdata <= {27'h0, debug_state, trap_flag, run_flag};
                    `A_EXT_HI:  avs_readdata <= {20'h0, ext_hi_r};
                    `A_EXT_LO:  avs_readdata <= {20'h0, ext_lo_r};
                    `A_PC:      avs_readdata <= {8'h0, program_counter_r};
                    `A_DMA_ADR: avs_readdata <= {18'h0, dma_adr_r};
                    `A_DMA_LO:  avs_readdata <= dma_rd[31:0];
                    `A_DMA_HI:  avs_readdata <= {4'h0, dma_rd[59:32]};
                    `A_DECODE:  avs_readdata <= {21'h0, opcode, group_id};
                    default:    avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    //--------------------------------------------------------------
    // Host-written staging registers
    //--------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ext_hi_r  <= 12'h000;
            ext_lo_r  <= 12'h000;
            dma_adr_r <= 14'h0000;
            dma_lo_r  <= 32'h0;
        end else if (bus_wr) begin
            case (avs_address)
                `A_EXT_HI:  ext_hi_r  <= avs_writedata[11:0];
                `A_EXT_LO:  ext_lo_r  <= avs_writedata[11:0];
                `A_DMA_ADR: dma_adr_r <= avs_writedata[13:0];
                `A_DMA_LO:  dma_lo_r  <= avs_writedata;
                default:    dma_lo_r  <= dma_lo_r;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Control state machine
    //--------------------------------------------------------------
    // Octal code of a state, shown for debugging
    function [2:0] enc;
        input [4:0] s;
        begin
            case (s)
                S_IDLE:   enc = 3'o0;
                S_FETCH:  enc = 3'o1;
                S_DECODE: enc = 3'o2;
                S_OPER:   enc = 3'o3;
                S_MICRO:  enc = 3'o4;
                default:  enc = 3'o7;
            endcase
        end
    endfunction

    wire ctl_wr = bus_wr & (avs_address == `A_CTRL);
    wire cmd_clear = ctl_wr & avs_writedata[`C_CLEAR];
    wire cmd_halt  = ctl_wr & avs_writedata[`C_HALT];
    wire cmd_cont  = ctl_wr & avs_writedata[`C_CONT];
    wire cmd_ldpc  = ctl_wr & avs_writedata[`C_LDPC] & stopped;

    // Halt only clears the flag; the machine looks at it at instruction end
    always @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r           <= S_IDLE;
            debug_state       <= 3'o0;
            run_flag          <= 1'b0;
            trap_flag         <= 1'b0;
            program_counter_r <= 24'h0;
            ir_r              <= 60'h0;
            prefetch_r        <= 60'h0;
            upc_r             <= 12'h000;
            sp_r              <= 6'h00;
            uctr_r            <= 12'h000;
            src1_r            <= 16'h0;
            src2_r            <= 16'h0;
            dst_r             <= 12'h000;
            group_id          <= 4'h0;
            micro_enable      <= 60'h0;
        end else if (cmd_clear) begin
            state_r      <= S_IDLE;
            debug_state  <= enc(S_IDLE);
            run_flag     <= 1'b0;
            trap_flag    <= 1'b0;
            sp_r         <= 6'h00;
            micro_enable <= 60'h0;
        end else begin
            if (cmd_halt)
                run_flag <= 1'b0;
            else if (cmd_cont)
                run_flag <= 1'b1;
            if (cmd_ldpc)
                program_counter_r <= {ext_hi_r, ext_lo_r};
            micro_enable <= 60'h0;
            case (state_r)
                S_IDLE: begin
                    if (run_flag) begin
                        state_r     <= S_FETCH;
                        debug_state <= enc(S_FETCH);
                    end
                end
                S_FETCH: begin
                    ir_r              <= instruction_memory[program_counter_r[11:0]];
                    program_counter_r <= program_counter_r + 24'h1;
                    state_r           <= S_DECODE;
                    debug_state       <= enc(S_DECODE);
                end
                S_DECODE: begin
                    group_id <= grp;
                    if (bad_mode | (grp == 4'h0)) begin
                        trap_flag   <= 1'b1;
                        run_flag    <= 1'b0;
                        state_r     <= S_IDLE;
                        debug_state <= enc(S_IDLE);
                    end else begin
                        // Lookahead word; dropped if the instruction jumps
                        prefetch_r  <= instruction_memory[program_counter_r[11:0]];
                        state_r     <= S_OPER;
                        debug_state <= enc(S_OPER);
                    end
                end
                S_OPER: begin
                    src1_r      <= src1;
                    src2_r      <= src2;
                    dst_r       <= dst;
                    upc_r       <= {opcode, 5'h00};
                    state_r     <= S_MICRO;
                    debug_state <= enc(S_MICRO);
                end
                S_MICRO: begin
                    micro_enable <= uword;
                    case (useq)
                        `SQ_JUMP: upc_r <= uadr;
                        `SQ_CALL: begin
                            upc_r <= uadr;
                            sp_r  <= sp_r + 6'h01;
                        end
                        `SQ_RET: begin
                            upc_r <= ret_stack[sp_dec];
                            sp_r  <= sp_dec;
                        end
                        `SQ_LOAD: begin
                            uctr_r <= uadr;
                            upc_r  <= upc_inc;
                        end
                        `SQ_INC: begin
                            uctr_r <= uctr_r + 12'h001;
                            upc_r  <= upc_inc;
                        end
                        `SQ_DEC: begin
                            uctr_r <= uctr_r - 12'h001;
                            upc_r  <= upc_inc;
                        end
                        `SQ_END: begin
                            if (jump_hit) begin
                                program_counter_r <= {12'h000, dst_r};
                                state_r     <= run_flag ? S_FETCH : S_IDLE;
                                debug_state <= enc(run_flag ? S_FETCH : S_IDLE);
                            end else if (run_flag) begin
                                ir_r              <= prefetch_r;
                                program_counter_r <= program_counter_r + 24'h1;
                                state_r           <= S_DECODE;
                                debug_state       <= enc(S_DECODE);
                            end else begin
                                state_r     <= S_IDLE;
                                debug_state <= enc(S_IDLE);
                            end
                        end
                        default: upc_r <= upc_inc;
                    endcase
                end
                default: begin
                    state_r     <= S_IDLE;
                    debug_state <= enc(S_IDLE);
                end
            endcase
        end
    end
endmodule

/* verification/ppc_chk.sv */
// Port-level checker for the picture processor control block
module ppc_chk (
    input logic        core_clk,        // System clock
    input logic        reset_n,         // Reset, active low
    input logic [5:0]  avs_address,     // Byte address
    input logic        avs_read,        // Read request
    input logic        avs_write,       // Write request
    input logic [31:0] avs_writedata,   // Write data
    input logic [31:0] avs_readdata,    // Read data
    input logic        avs_waitrequest, // Slave busy
    input logic [59:0] micro_enable,    // Microcode enable bus
    input logic [2:0]  debug_state,     // Next-state code
    input logic        run_flag,        // Run flip-flop
    input logic        trap_flag,       // Trap flag
    input logic [3:0]  group_id         // Operator group
);
    timeunit 1ns;
    timeprecision 1ns;
    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic ctrl_wr;
    assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == 6'h00;
    wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low longer than one cycle");
    wait_answer_a: assert property ($rose(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    hole_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 6'h1C |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    trap_stop_a: assert property ($rose(trap_flag) |-> !run_flag)
        else $error("trap left processor running");
    trap_keep_a: assert property (trap_flag && !(ctrl_wr && avs_writedata[2]) |=> trap_flag)
        else $error("trap flag lost");
    run_cont_a: assert property (ctrl_wr && avs_writedata[2:0] == 3'h1 |=> run_flag)
        else $error("continue did not set run");
    halt_wins_a: assert property (ctrl_wr && avs_writedata[1] && !run_flag |=> !run_flag)
        else $error("halt lost against continue");
    clear_all_a: assert property (ctrl_wr && avs_writedata[2] |=> !run_flag && !trap_flag)
        else $error("clear left run or trap set");
    state_octal_a: assert property (debug_state <= 3'h4)
        else $error("state code out of range");
    group_range_a: assert property (group_id <= 4'hD)
        else $error("group out of range");
    // Halt lets the instruction finish, so quiet enables follow the idle state, not the run flag
    idle_quiet_a: assert property ((debug_state == 3'h0) [*2] |-> micro_enable == 60'h0)
        else $error("enables active while idle");
endmodule

bind picture_processor_control_decode ppc_chk u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .micro_enable(micro_enable), .debug_state(debug_state),
    .run_flag(run_flag), .trap_flag(trap_flag), .group_id(group_id));

/* verification/avalon_host.sv */
// Avalon-MM host model standing for the controlling minicomputer
module avalon_host (
    input  logic        core_clk,        // System clock
    output logic [5:0]  avs_address,     // Byte address
    output logic        avs_read,        // Read request
    output logic        avs_write,       // Write request
    output logic [31:0] avs_writedata,   // Write data
    input  logic [31:0] avs_readdata,    // Read data
    input  logic        avs_waitrequest  // Slave busy
);
    timeunit 1ns;
    timeprecision 1ns;
    int timeouts = 0;
    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // One access; the slave's pace is never assumed, only bounded
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        q = avs_readdata;
        if (avs_waitrequest !== 1'b0) timeouts++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        avs_writedata <= ~d;    // Released data must not look valid
    endtask
endmodule

/* verification/picture_processor_control_decode_tb.sv */
// Self-checking bench for the picture processor control block
`include "ppc_map.vh"
module picture_processor_control_decode_tb;
    timeunit 1ns;
    timeprecision 1ns;
    //------------------------------------------------------------
    // Harness
    //------------------------------------------------------------
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [5:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest, run_flag, trap_flag;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [59:0] micro_enable;
    logic [2:0]  debug_state;
    logic [3:0]  group_id;
    int          fail_count = 0;
    int          checked = 0;
    always #25 core_clk = ~core_clk;
    picture_processor_control_decode u_dut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .micro_enable(micro_enable),
        .debug_state(debug_state), .run_flag(run_flag), .trap_flag(trap_flag), .group_id(group_id));
    avalon_host u_host (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    task automatic check(input logic [59:0] seen, input logic [59:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_host.xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] r);
        u_host.xfer(1'b0, a, 32'h0, r);
    endtask
    // Stage a word then commit it; only used while stopped
    task automatic put(input logic [1:0] t, input logic [11:0] i, input logic [59:0] w);
        wr(`A_DMA_ADR, {18'h0, t, i});
        wr(`A_DMA_LO, w[31:0]);
        wr(`A_DMA_HI, {4'h0, w[59:32]});
    endtask
    task automatic peek(input logic [11:0] i, output logic [31:0] r);
        wr(`A_DMA_ADR, {18'h0, `T_DATA, i});
        rd(`A_DMA_LO, r);
    endtask
    // Clear, load start address, continue, then wait for the trap
    task automatic run_from(input logic [23:0] pc);
        int n;
        wr(`A_CTRL, 32'h4);
        wr(`A_EXT_HI, {20'h0, pc[23:12]});
        wr(`A_EXT_LO, {20'h0, pc[11:0]});
        wr(`A_CTRL, 32'h8);
        wr(`A_CTRL, 32'h1);
        n = 0;
        while (trap_flag !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 3000) begin
            fail_count++;
            results();
        end
    endtask
    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    task automatic sc_regs;
        wr(`A_CTRL, 32'h3);
        rd(`A_CTRL, q);
        check(q, 32'h0);
        rd(6'h3C, q);
        check(q, 32'h0);
        wr(`A_EXT_HI, 32'hFFFF_FABC);
        rd(`A_EXT_HI, q);
        check(q[11:0], 12'hABC);
        wr(`A_EXT_LO, 32'h0000_0123);
        wr(`A_CTRL, 32'h8);
        rd(`A_PC, q);
        check(q[23:0], 24'hABC123);
        $display("test regs done");
    endtask
    // Move immediate, add through indirect source and destination, jump over one word, then trap
    task automatic sc_program;
        put(`T_UCODE, 12'h000, 60'h800000000007000);
        put(`T_UCODE, 12'h040, 60'h400000000007000);
        put(`T_UCODE, 12'hA00, 60'h80000000000F000);
        put(`T_DATA, 12'h008, 60'h3);
        put(`T_DATA, 12'h009, 60'hB);
        put(`T_DATA, 12'h00B, 60'h4);
        put(`T_DATA, 12'h00A, 60'h7);
        put(`T_DATA, 12'h006, 60'h1111);
        put(`T_PROG, 12'h000, {12'h200, 16'h0005, 16'hFFFF, 16'h0000});
        put(`T_PROG, 12'h001, {12'h950, 16'h000A, 16'h0008, 16'h0009});
        put(`T_PROG, 12'h002, {12'h002, 16'h0004, 16'h0000, 16'h0000});
        put(`T_PROG, 12'h003, {12'h200, 16'h0006, 16'h0222, 16'h0000});
        put(`T_PROG, 12'h004, {12'h600, 16'h0006, 16'h0008, 16'h0009});
        run_from(24'h0);
        rd(`A_CTRL, q);
        check(q[4:0], 5'h02);
        rd(`A_PC, q);
        check(q[23:0], 24'h5);
        rd(`A_DECODE, q);
        check(q, 32'h1);
        peek(12'h005, q);
        check(q[15:0], 16'h0FFF);
        peek(12'h007, q);
        check(q[15:0], 16'h0007);
        peek(12'h006, q);
        check(q[15:0], 16'h1111);
        $display("test program done");
    endtask
    // Both source mode fields trap code 11, as does an opcode outside the groups; none stores
    task automatic sc_traps;
        logic [11:0] op [3] = '{12'h600, 12'h180, 12'h06C};
        for (int k = 0; k < 3; k++) begin
            put(`T_PROG, 12'h003, {op[k], 16'h0006, 16'h0008, 16'h0009});
            run_from(24'h3);
            check({trap_flag, run_flag}, 2'b10);
            peek(12'h006, q);
            check(q[15:0], 16'h1111);
        end
        check(u_host.timeouts, 0);
        $display("test traps done");
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        sc_regs();
        sc_program();
        sc_traps();
        results();
    end
endmodule
